// [verilog/sfch_top.sv]
// Flow control of a start-stop serial port toward a computer.
// Assumes an outside framer: it strobes received characters in and shifts
// out each character started here, raising TX_BUSY the cycle after start.
// Operation
// - Outgoing characters go to the transmit line
// - Incoming characters from receive line accepted
// - RTS output serves receive flow control only
// - CTS input paces outgoing transmission only
// - Four methods pair send and receive control
// - No handshake: pacing characters stored as data
// - No handshake: transmit ignores CTS
// - Full receive buffer drops further characters
// - RTS held true unless hardware receive control
// - Software send: stop on XOFF, resume XON
// - Software receive: XOFF at 64 free, XON 192
// - Hardware receive: RTS false 64, true 192
// - Hardware send: pause while CTS false
module sfch_top #(
  parameter int DEPTH = sfch_pkg::SFCH_RX_DEPTH
) (
  // Clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic CE,
  // Method selection
  input wire logic [1:0] MODE,
  // Received characters from the framer
  input wire logic [7:0] RX_CHAR,
  input wire logic RX_STB,
  // Modem control pins
  input wire logic CTS,
  output logic RTS,
  // Characters to the framer
  output logic [7:0] TX_CHAR,
  output logic TX_START,
  input wire logic TX_BUSY,
  // Data to send, from the user
  input wire logic [7:0] SRC_DATA,
  input wire logic SRC_VALID,
  output logic SRC_READY,
  // Received data, to the user
  output logic [7:0] SNK_DATA,
  output logic SNK_VALID,
  input wire logic SNK_READY,
  // Character lost to a full buffer
  output logic RX_DROP
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  // Elaboration check: depth must hold both thresholds
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || DEPTH <= sfch_pkg::SFCH_HIGH_FREE)
  begin : g_bad_depth
    $error("sfch_top depth must be a power of two above the release threshold");
  end

  sfch_pkg::sfch_mode_t mode; // Decoded method
  logic sw_send; // Software pacing of transmit
  logic hw_send; // CTS pacing of transmit
  logic sw_rx; // Pacing characters for receive
  logic hw_rx; // RTS for receive

  // Method decode
  assign mode = sfch_pkg::sfch_mode_t'(MODE);
  assign sw_send = (mode == sfch_pkg::software_both_ways_method) ||
                   (mode == sfch_pkg::software_send_hardware_receive_method);
  assign hw_send = (mode == sfch_pkg::hardware_both_ways_method);
  assign sw_rx = (mode == sfch_pkg::software_both_ways_method);
  assign hw_rx = (mode == sfch_pkg::software_send_hardware_receive_method) ||
                 (mode == sfch_pkg::hardware_both_ways_method);

  // Receive buffer state
  logic [7:0] rx_mem [DEPTH]; // Receive storage
  logic [AW-1:0] wr_reg, wr_next; // Write pointer
  logic [AW-1:0] rd_reg, rd_next; // Read pointer
  logic [CW-1:0] cnt_reg, cnt_next; // Fill level
  logic [CW-1:0] free_now; // Free space
  logic [7:0] snk_data_reg, snk_data_next; // Output word
  logic snk_valid_reg, snk_valid_next; // Output word held
  logic drop_reg, drop_next; // Drop pulse
  logic is_pace; // Pacing character received
  logic consume; // Pacing character acted on
  logic full; // No room
  logic store; // Write one character
  logic pop; // Move one to the output

  // Receive path terms
  assign free_now = CW'(DEPTH) - cnt_reg;
  assign full = (cnt_reg == CW'(DEPTH));
  assign is_pace = (RX_CHAR == sfch_pkg::SFCH_XON) || (RX_CHAR == sfch_pkg::SFCH_XOFF);
  assign consume = RX_STB && sw_send && is_pace;
  assign store = RX_STB && !consume && !full;
  assign pop = (cnt_reg != '0) && (!snk_valid_reg || SNK_READY);

  // Next receive buffer state
  always_comb begin
    wr_next = store ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + CW'(store) - CW'(pop);
    snk_data_next = pop ? rx_mem[rd_reg] : snk_data_reg;
    snk_valid_next = pop || (snk_valid_reg && !SNK_READY);
    drop_next = RX_STB && !consume && full;
  end

  // Register receive buffer state
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      snk_data_reg <= '0;
      snk_valid_reg <= 1'b0;
      drop_reg <= 1'b0;
    end else if (CE) begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      snk_data_reg <= snk_data_next;
      snk_valid_reg <= snk_valid_next;
      drop_reg <= drop_next;
    end
  end

  // Receive storage write
  always_ff @(posedge CLK_SYS) begin
    if (CE && store) begin
      rx_mem[wr_reg] <= RX_CHAR;
    end
  end

  // Throttle and pacing state
  sfch_pkg::sfch_flow_t flow_reg, flow_next; // Receive throttle
  logic rts_reg, rts_next; // RTS pin
  logic xoff_reg, xoff_next; // Transmit held by XOFF
  logic pend_reg, pend_next; // Pacing character to send
  logic [7:0] pchar_reg, pchar_next; // Which one
  sfch_pkg::sfch_txchar_t tx_reg, tx_next; // Framer request
  logic can_start; // Framer idle
  logic send_ok; // Data may start
  logic send_ctl; // Start pacing character
  logic buf_valid; // Stall buffer has data
  logic buf_ready; // Take from stall buffer
  logic [7:0] buf_data; // Stall buffer head

  // A new character starts only after the last one ended
  assign can_start = !TX_BUSY && !tx_reg.start;
  // Method-dependent send permission
  assign send_ok = sw_send ? !xoff_reg : (hw_send ? CTS : 1'b1);
  assign send_ctl = can_start && pend_reg;
  assign buf_ready = can_start && !pend_reg && send_ok;

  // Next throttle, pacing and transmit state
  always_comb begin
    flow_next = flow_reg;
    unique case (flow_reg)
      sfch_pkg::flow_open: begin
        if (free_now <= CW'(sfch_pkg::SFCH_LOW_FREE)) begin
          flow_next = sfch_pkg::flow_held;
        end
      end
      sfch_pkg::flow_held: begin
        if (free_now >= CW'(sfch_pkg::SFCH_HIGH_FREE)) begin
          flow_next = sfch_pkg::flow_open;
        end
      end
    endcase
    // RTS true unless hardware receive control holds it
    rts_next = !(hw_rx && flow_next == sfch_pkg::flow_held);
    // XOFF holds, XON releases; cleared outside software send
    xoff_next = xoff_reg;
    if (!sw_send) begin
      xoff_next = 1'b0;
    end else if (consume) begin
      xoff_next = (RX_CHAR == sfch_pkg::SFCH_XOFF);
    end
    // Pacing request; a new edge wins over the send that clears it
    pend_next = pend_reg && !send_ctl;
    pchar_next = pchar_reg;
    if (sw_rx && flow_reg != flow_next) begin
      pend_next = 1'b1;
      pchar_next = (flow_next == sfch_pkg::flow_held) ? sfch_pkg::SFCH_XOFF
                                                      : sfch_pkg::SFCH_XON;
    end else if (!sw_rx) begin
      pend_next = 1'b0;
    end
    // One-cycle start toward the framer
    tx_next.start = send_ctl || (buf_ready && buf_valid);
    tx_next.data = send_ctl ? pchar_reg : (buf_valid ? buf_data : tx_reg.data);
  end

  // Register throttle, pacing and transmit state
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      flow_reg <= sfch_pkg::flow_open;
      rts_reg <= 1'b1;
      xoff_reg <= 1'b0;
      pend_reg <= 1'b0;
      pchar_reg <= sfch_pkg::SFCH_XON;
      tx_reg <= '0;
    end else if (CE) begin
      flow_reg <= flow_next;
      rts_reg <= rts_next;
      xoff_reg <= xoff_next;
      pend_reg <= pend_next;
      pchar_reg <= pchar_next;
      tx_reg <= tx_next;
    end
  end

  // Stall buffer between the user and the transmitter
  sfch_buf #(
    .W(sfch_pkg::SFCH_CHAR_W),
    .DEPTH(sfch_pkg::SFCH_TX_BUF_DEPTH)
  ) u_txbuf (
    .clk(CLK_SYS),
    .nrst(NRST),
    .ce(CE),
    .in_data(SRC_DATA),
    .in_valid(SRC_VALID),
    .in_ready(SRC_READY),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready && CE)
  );

  // Output drive
  assign RTS = rts_reg;
  assign TX_CHAR = tx_reg.data;
  assign TX_START = tx_reg.start;
  assign SNK_DATA = snk_data_reg;
  assign SNK_VALID = snk_valid_reg;
  assign RX_DROP = drop_reg;

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  a_rts_fixed_true: assert property (CE && !hw_rx |=> RTS)
    else $error("RTS not held true outside hardware receive");
  a_rts_falls_low: assert property (CE && hw_rx && flow_reg == sfch_pkg::flow_open &&
      free_now <= CW'(sfch_pkg::SFCH_LOW_FREE) |=> !RTS)
    else $error("RTS not dropped at low free space");
  a_cts_pauses: assert property (CE && hw_send && !CTS && !pend_reg |=> !TX_START)
    else $error("Transmit started while CTS false");
  a_none_ignores_cts: assert property (CE && mode == sfch_pkg::none_method &&
      can_start && buf_valid |=> TX_START)
    else $error("Transmit held without handshake");
  a_xoff_holds_tx: assert property (CE && sw_send && RX_STB &&
      RX_CHAR == sfch_pkg::SFCH_XOFF ##1 CE && !pend_reg |=> !TX_START)
    else $error("Transmit started after XOFF");
  a_pace_as_data: assert property (CE && mode == sfch_pkg::none_method && RX_STB &&
      is_pace && !full |=> wr_reg == $past(wr_reg) + 1'b1)
    else $error("Pacing character not stored without handshake");
  a_full_drops: assert property (CE && RX_STB && !consume && full |=>
      RX_DROP && wr_reg == $past(wr_reg))
    else $error("Character not dropped at full buffer");
  a_xoff_queued: assert property (CE && sw_rx && flow_reg == sfch_pkg::flow_open &&
      free_now <= CW'(sfch_pkg::SFCH_LOW_FREE) |=>
      pend_reg && pchar_reg == sfch_pkg::SFCH_XOFF)
    else $error("XOFF not queued at low free space");
  // A frozen block keeps its start pulse, so only enabled cycles count
  a_busy_no_start: assert property (CE && TX_BUSY |=> !TX_START)
    else $error("Start while framer busy");

  c_xoff_sent: cover property (TX_START && TX_CHAR == sfch_pkg::SFCH_XOFF);
  c_rx_drop: cover property (RX_DROP);
  c_rts_fall: cover property ($fell(RTS));
  c_cts_stall: cover property (hw_send && !CTS && buf_valid ##2 TX_START);

endmodule // sfch_top

// [verilog/sfch_pkg.sv]
// Shared constants and types of the serial flow-control block.
// Assumes one 100 MHz system clock and a character-level framer outside.
package sfch_pkg;

  // Handshake method codes, as selected by the user
  typedef enum logic [1:0] {
    none_method                           = 2'b00,
    software_both_ways_method             = 2'b01,
    software_send_hardware_receive_method = 2'b10,
    hardware_both_ways_method             = 2'b11
  } sfch_mode_t;

  // Receive throttle state
  typedef enum logic {
    flow_open = 1'b0,
    flow_held = 1'b1
  } sfch_flow_t;

  // One character handed to the framer
  typedef struct packed {
    logic       start;
    logic [7:0] data;
  } sfch_txchar_t;

  // Pacing characters
  localparam logic [7:0] SFCH_XON = 8'h11;
  localparam logic [7:0] SFCH_XOFF = 8'h13;

  // Receive buffer size and free-space thresholds, in bytes
  localparam int SFCH_RX_DEPTH = 256;
  localparam int SFCH_LOW_FREE = 64;
  localparam int SFCH_HIGH_FREE = 192;

  // Depth of the transmit-side stall buffer
  localparam int SFCH_TX_BUF_DEPTH = 2;

  // Character width
  localparam int SFCH_CHAR_W = 8;

endpackage

// [verilog/sfch_buf.sv]
// Small ring buffer with valid/ready on both sides.
// Assumes a synchronous consumer; a stalled consumer backs up into in_ready.
module sfch_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Filling side
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Elaboration check: power-of-two depth of at least two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("sfch_buf depth must be a power of two, at least 2");
  end

  logic [W-1:0] mem [DEPTH]; // Storage
  logic [AW-1:0] wr_reg, wr_next; // Write pointer
  logic [AW-1:0] rd_reg, rd_next; // Read pointer
  logic [AW:0] cnt_reg, cnt_next; // Fill level
  logic rdy_reg, rdy_next; // Room for one more word, registered
  logic push; // Word taken in
  logic pop; // Word handed out

  // Handshake terms
  // Ready comes from a flop so the top's port is registered
  assign in_ready = rdy_reg;
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next pointers and level
  always_comb begin
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    rdy_next = (cnt_next != (AW+1)'(DEPTH));
  end

  // Register pointers and level
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b1;
    end else if (ce) begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
    end
  end

  // Storage write, no reset needed
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_reg] <= in_data;
    end
  end

endmodule // sfch_buf

// [dv/sfch_framer_model.sv]
// Behavioural model of the character framer and line toward the computer.
// Assumes one clock; busy rises the cycle after a start and holds LEN cycles.
module sfch_framer_model #(
  parameter int LEN = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Start of one character
  input wire logic tx_start,
  // Busy while the character is shifted
  output logic tx_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt; // Remaining shift cycles

  // Load on start, count down while shifting
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
    end else if (tx_start) begin
      cnt <= LEN;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
  assign tx_busy = (cnt != 0);
endmodule // sfch_framer_model

// [dv/tb_serial_flow_control_handshake.sv]
// Self-checking bench of the serial flow-control block.
// Assumes the framer model above and the constants of the block's package.
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH t=%0t got %h want %h", $time, a, b); end end
module tb_serial_flow_control_handshake;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, nrst = 0, ce = 1, rx_stb = 0, cts = 1, src_valid = 0, snk_ready = 1;
  logic [1:0] mode = 2'h0;
  logic [7:0] rx_char = 8'h00, src_data = 8'h00;
  logic rts, tx_start, tx_busy, src_ready, snk_valid, rx_drop;
  logic [7:0] tx_char, snk_data, last_tx;
  logic [7:0] rxq[$]; // Words taken at the user side
  int fail_count = 0, num_checks = 0, n_tx = 0, n_drop = 0;

  sfch_top dut (.CLK_SYS(clk_sys), .NRST(nrst), .CE(ce), .MODE(mode), .RX_CHAR(rx_char),
    .RX_STB(rx_stb), .CTS(cts), .RTS(rts), .TX_CHAR(tx_char), .TX_START(tx_start),
    .TX_BUSY(tx_busy), .SRC_DATA(src_data), .SRC_VALID(src_valid), .SRC_READY(src_ready),
    .SNK_DATA(snk_data), .SNK_VALID(snk_valid), .SNK_READY(snk_ready), .RX_DROP(rx_drop));
  sfch_framer_model #(.LEN(12)) framer (.clk(clk_sys), .nrst(nrst), .tx_start(tx_start),
    .tx_busy(tx_busy));

  // Free-running 100 MHz clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // Records what leaves on both sides
  always @(posedge clk_sys) begin
    if (snk_valid && snk_ready) rxq.push_back(snk_data);
    if (tx_start) begin
      last_tx = tx_char;
      n_tx++;
    end
    if (rx_drop) n_drop++;
  end

  // Payload that never equals a pacing character
  function automatic logic [7:0] dat(input int i);
    return 8'h20 + 8'(i % 64);
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Bounded wait for a new character start
  task automatic wait_tx(input int prev);
    int k;
    for (k = 0; k < 200 && n_tx == prev; k++) @(posedge clk_sys);
    if (n_tx == prev) begin
      fail_count++;
      $display("MISMATCH t=%0t no start", $time);
      conclude();
    end
  endtask

  // Single received character
  task automatic rxb(input logic [7:0] d);
    rx_char <= d;
    rx_stb <= 1'b1;
    @(posedge clk_sys);
    rx_stb <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Back-to-back burst of payload characters
  task automatic rxn(input int first, input int n);
    rx_stb <= 1'b1;
    for (int i = 0; i < n; i++) begin
      rx_char <= dat(first + i);
      @(posedge clk_sys);
    end
    rx_stb <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Offer one word until the buffer takes it
  task automatic send(input logic [7:0] d);
    int k;
    src_data <= d;
    src_valid <= 1'b1;
    k = 0;
    do begin @(posedge clk_sys); k++; end while (src_ready !== 1'b1 && k < 100);
    if (src_ready !== 1'b1) begin
      fail_count++;
      $display("MISMATCH t=%0t word not taken", $time);
      conclude();
    end
    src_valid <= 1'b0;
    @(posedge clk_sys);
  endtask

  // No handshake: pacing characters are data, CTS ignored
  task automatic s_none();
    int b;
    mode <= sfch_pkg::none_method;
    cts <= 1'b0;
    b = rxq.size();
    rxb(sfch_pkg::SFCH_XON);
    rxb(sfch_pkg::SFCH_XOFF);
    idle(4);
    `CHK(rxq.size(), b + 2)
    `CHK(rxq[b], sfch_pkg::SFCH_XON)
    `CHK(rxq[b + 1], sfch_pkg::SFCH_XOFF)
    b = n_tx;
    send(8'h55);
    wait_tx(b);
    `CHK(last_tx, 8'h55)
    `CHK(rts, 1'b1)
  endtask

  // Hardware send: CTS false blocks, pacing characters stay data
  task automatic s_hw();
    int b;
    mode <= sfch_pkg::hardware_both_ways_method;
    cts <= 1'b0;
    idle(20);
    b = n_tx;
    send(8'h66);
    idle(20);
    `CHK(n_tx, b)
    cts <= 1'b1;
    wait_tx(b);
    `CHK(last_tx, 8'h66)
    b = rxq.size();
    rxb(sfch_pkg::SFCH_XOFF);
    idle(4);
    `CHK(rxq.size(), b + 1)
  endtask

  // Software send: XOFF stops, XON resumes, CTS ignored
  task automatic s_sw();
    int b, r;
    mode <= sfch_pkg::software_both_ways_method;
    cts <= 1'b0;
    idle(20);
    r = rxq.size();
    rxb(sfch_pkg::SFCH_XOFF);
    b = n_tx;
    send(8'h44);
    idle(20);
    `CHK(n_tx, b)
    rxb(sfch_pkg::SFCH_XON);
    wait_tx(b);
    `CHK(last_tx, 8'h44)
    idle(2);
    `CHK(rxq.size(), r)
    cts <= 1'b1;
  endtask

  // Clock enable low freezes the block: a strobe then is not taken
  task automatic s_ce();
    int b;
    mode <= sfch_pkg::none_method;
    b = rxq.size();
    ce <= 1'b0;
    rxb(8'h30);
    idle(4);
    `CHK(snk_valid, 1'b0)
    ce <= 1'b1;
    idle(4);
    `CHK(rxq.size(), b)
  endtask

  // Fill with the user stalled, check throttle and drop, then drain in order
  task automatic s_fill(input logic [1:0] m);
    int b, t, k;
    mode <= m;
    snk_ready <= 1'b0;
    idle(20);
    b = rxq.size();
    rxn(0, 192);
    idle(4);
    `CHK(rts, 1'b1)
    t = n_tx;
    rxn(192, 1);
    idle(4);
    if (m == sfch_pkg::software_both_ways_method) begin
      wait_tx(t);
      `CHK(last_tx, sfch_pkg::SFCH_XOFF)
      `CHK(rts, 1'b1)
    end else begin
      `CHK(rts, 1'b0)
    end
    rxn(193, 64);
    idle(2);
    `CHK(n_drop, 0)
    rxb(8'h21);
    idle(2);
    `CHK(n_drop, 1)
    n_drop = 0;
    t = n_tx;
    snk_ready <= 1'b1;
    for (k = 0; k < 1000 && rxq.size() < b + 257; k++) @(posedge clk_sys);
    `CHK(rxq.size(), b + 257)
    if (k == 1000) conclude();
    for (int i = 0; i < 257; i++) `CHK(rxq[b + i], dat(i))
    if (m == sfch_pkg::software_both_ways_method) begin
      wait_tx(t);
      `CHK(last_tx, sfch_pkg::SFCH_XON)
    end else begin
      `CHK(rts, 1'b1)
    end
  endtask

  // Main sequence; the bench keeps the computer on the chosen method
  initial begin
    idle(3);
    `CHK(rts, 1'b1)
    `CHK(tx_start, 1'b0)
    `CHK(snk_valid, 1'b0)
    `CHK(src_ready, 1'b1)
    `CHK(rx_drop, 1'b0)
    nrst <= 1'b1;
    idle(1);
    s_none();
    s_hw();
    s_sw();
    s_fill(sfch_pkg::software_both_ways_method);
    s_fill(sfch_pkg::software_send_hardware_receive_method);
    s_ce();
    conclude();
  end

  // Watchdog on the whole run
  initial begin
    #900000;
    fail_count++;
    conclude();
  end
endmodule // tb_serial_flow_control_handshake
